// ==== hw/atc_pkg.sv ====
// Purpose: Shared constants and types for the analog threshold comparator.
// Assumes: 32-bit APB register bus, 100 MHz pclk.
// Notes: Quantity codes and register offsets are fixed here for all users.
package atc_pkg;

    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_THRESH = 8'h04;
    localparam logic [7:0] ADDR_BAND = 8'h08;
    localparam logic [7:0] ADDR_INTERVAL = 8'h0C;
    localparam logic [7:0] ADDR_ON_DELAY = 8'h10;
    localparam logic [7:0] ADDR_OFF_DELAY = 8'h14;
    localparam logic [7:0] ADDR_STATUS = 8'h18;
    localparam logic [7:0] ADDR_OPSIG = 8'h1C;

    localparam int CTRL_POS_EN = 0;
    localparam int CTRL_NEG_EN = 1;
    localparam int CTRL_MAG = 2;
    localparam int CTRL_RATE = 3;
    localparam int CTRL_UNDER = 4;
    localparam int CTRL_UNIT = 5;
    localparam int CTRL_W = 6;

    localparam int STAT_FLAG = 0;
    localparam int STAT_PICKUP = 1;
    localparam int STAT_MISMATCH = 2;
    localparam int STAT_INHIBIT = 3;

    localparam logic [5:0] CTRL_RST = 6'h01;
    localparam logic [31:0] THRESH_RST = 32'h0001_0000;
    localparam logic [7:0] BAND_RST = 8'h02;
    localparam logic [7:0] INTERVAL_RST = 8'h01;
    localparam logic [15:0] DELAY_RST = 16'h0000;

    localparam logic [3:0] QTY_FREQ = 4'h1;
    localparam logic [3:0] QTY_FREQ_RATE = 4'h2;
    localparam logic [3:0] QTY_ANGLE = 4'h3;
    localparam logic [3:0] QTY_ENERGY_P = 4'h4;
    localparam logic [3:0] QTY_ENERGY_Q = 4'h5;

    localparam logic [15:0] BASE_FREQ = 16'h0001;
    localparam logic [15:0] BASE_FREQ_RATE = 16'h0001;
    localparam logic [15:0] BASE_ANGLE = 16'h0168;
    localparam logic [15:0] BASE_ENERGY = 16'h2710;
    localparam logic [15:0] BASE_UNITY = 16'h0001;

    localparam int UNIT_SHIFT = 4;
    localparam logic signed [63:0] PCT_FULL = 64'sh64;

    localparam int CLK_PERIOD_NS = 10;
    localparam int TICK_TIME_NS = 1000000;
    localparam int TICK_CYCLES = TICK_TIME_NS / CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ARMING,
        ST_ACTIVE,
        ST_RELEASING
    } atc_state_t;

endpackage

// ==== hw/atc_comparator.sv ====
// Purpose: Configurable level or rate comparator with hysteresis and delays.
// Assumes: Samples arrive as signed Q16.16 values on pclk with a valid pulse.
// Notes: Delays count 1 ms ticks; the rate is evaluated once per interval.

// Operation
// RQ1 - An input switched off contributes zero to the operating signal.
// RQ2 - The operating difference is the positive input minus the negative.
// RQ3 - With both inputs off the output flags are never asserted.
// RQ4 - Two enabled inputs of different quantity types keep outputs low.
// RQ5 - Signed mode uses the difference, magnitude mode its absolute value.
// RQ6 - Level mode compares the signal, rate mode its change over time.
// RQ7 - The rate interval and its unit only matter in rate mode.
// RQ8 - Over picks up above the threshold, under picks up below it.
// RQ9 - The dropout band is a percentage of the pickup threshold.
// RQ10 - Signals and thresholds are signed throughout the arithmetic.
// RQ11 - Thresholds are per unit, with 1 Hz and 1 Hz/s frequency bases.
// RQ12 - Phase angles use a per-unit base of 360 degrees.
// RQ13 - Active and reactive energy use a per-unit base of 10000.
// RQ14 - Assertion waits the on delay and release waits the off delay.
// RQ15 - The rate is the change over one interval divided by its length.
// RQ16 - Dropout needs the signal past the threshold by the band width.
module atc_comparator #(
    parameter int TICK_CYCLES = atc_pkg::TICK_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sample_valid,
    input wire logic signed [31:0] pos_value,
    input wire logic [3:0] pos_type,
    input wire logic signed [31:0] neg_value,
    input wire logic [3:0] neg_type,
    output logic element_operate,
    output logic element_pickup
);

    typedef struct packed {
        logic [atc_pkg::CTRL_W-1:0] ctrl;
        logic [31:0] thresh;
        logic [7:0] band;
        logic [7:0] interval;
        logic [15:0] on_delay;
        logic [15:0] off_delay;
        logic [31:0] prdata;
        logic raw;
        logic flag;
        logic mismatch;
        logic inhibit;
        logic [34:0] op;
        logic [34:0] snap;
        logic have_snap;
        logic [11:0] scnt;
        atc_pkg::atc_state_t state;
        logic [15:0] dcnt;
        logic [16:0] tick;
    } atc_state_s_t;

    atc_state_s_t st_r;
    atc_state_s_t st_nxt;

    logic signed [34:0] pos_s;
    logic signed [34:0] neg_s;
    logic signed [34:0] diff;
    logic signed [34:0] opsig;
    logic signed [63:0] sig;
    logic signed [63:0] thr_n;
    logic signed [63:0] thr_c;
    logic signed [63:0] thr_abs;
    logic signed [63:0] band_w;
    logic [15:0] base;
    logic [11:0] ivl_eff;
    logic [11:0] scnt_inc;
    logic eval;
    logic pick;
    logic drop;
    logic blocked;
    logic tick_hit;
    logic wr_en;

    function automatic logic addr_ok(input logic [7:0] a);
        return (a[1:0] == 2'h0) && (a <= atc_pkg::ADDR_OPSIG);
    endfunction

    function automatic logic [15:0] qty_base(input logic [3:0] q);
        logic [15:0] b;
        b = atc_pkg::BASE_UNITY;
        if (q == atc_pkg::QTY_FREQ)
        begin
            b = atc_pkg::BASE_FREQ;
        end
        else if (q == atc_pkg::QTY_FREQ_RATE)
        begin
            b = atc_pkg::BASE_FREQ_RATE;
        end
        else if (q == atc_pkg::QTY_ANGLE)
        begin
            b = atc_pkg::BASE_ANGLE;
        end
        else if (q == atc_pkg::QTY_ENERGY_P || q == atc_pkg::QTY_ENERGY_Q)
        begin
            b = atc_pkg::BASE_ENERGY;
        end
        return b;
    endfunction

    always_comb
    begin
        st_nxt = st_r;
        // Disabled inputs are replaced by zero. [RQ1]
        pos_s = st_r.ctrl[atc_pkg::CTRL_POS_EN] ? 35'(pos_value) : '0;
        neg_s = st_r.ctrl[atc_pkg::CTRL_NEG_EN] ? 35'(neg_value) : '0;
        diff = pos_s - neg_s; // [RQ2] [RQ10]
        opsig = (st_r.ctrl[atc_pkg::CTRL_MAG] && diff[34])
            ? -diff : diff; // [RQ5]
        // The base follows the selected quantity. [RQ11] [RQ12] [RQ13]
        base = qty_base(st_r.ctrl[atc_pkg::CTRL_POS_EN] ? pos_type : neg_type);
        thr_n = 64'($signed(st_r.thresh)) * $signed({48'h0, base});
        ivl_eff = st_r.ctrl[atc_pkg::CTRL_UNIT]
            ? {st_r.interval, 4'h0} : {4'h0, st_r.interval}; // [RQ7]
        if (ivl_eff == 12'h000)
        begin
            ivl_eff = 12'h001;
        end
        scnt_inc = st_r.scnt + 12'h001;
        // Rate compares the change with threshold times length. [RQ6] [RQ15]
        if (st_r.ctrl[atc_pkg::CTRL_RATE])
        begin
            sig = 64'(opsig - $signed(st_r.snap));
            thr_c = thr_n * $signed({52'h0, ivl_eff});
        end
        else
        begin
            sig = 64'(opsig);
            thr_c = thr_n;
        end
        thr_abs = thr_c[63] ? -thr_c : thr_c;
        band_w = (thr_abs * $signed({56'h0, st_r.band}))
            / atc_pkg::PCT_FULL; // [RQ9]
        if (st_r.ctrl[atc_pkg::CTRL_UNDER])
        begin
            pick = sig < thr_c; // [RQ8]
            drop = sig > thr_c + band_w; // [RQ16]
        end
        else
        begin
            pick = sig > thr_c; // [RQ8]
            drop = sig < thr_c - band_w; // [RQ16]
        end
        st_nxt.inhibit = !st_r.ctrl[atc_pkg::CTRL_POS_EN]
            && !st_r.ctrl[atc_pkg::CTRL_NEG_EN]; // [RQ3]
        st_nxt.mismatch = st_r.ctrl[atc_pkg::CTRL_POS_EN]
            && st_r.ctrl[atc_pkg::CTRL_NEG_EN]
            && (pos_type != neg_type); // [RQ4]
        blocked = st_nxt.inhibit || st_nxt.mismatch;
        eval = 1'b0;
        if (sample_valid)
        begin
            st_nxt.op = opsig;
            if (st_r.ctrl[atc_pkg::CTRL_RATE])
            begin
                if (scnt_inc >= ivl_eff)
                begin
                    st_nxt.scnt = 12'h000;
                    st_nxt.snap = opsig;
                    st_nxt.have_snap = 1'b1;
                    eval = st_r.have_snap; // [RQ15]
                end
                else
                begin
                    st_nxt.scnt = scnt_inc;
                end
            end
            else
            begin
                st_nxt.scnt = 12'h000;
                st_nxt.have_snap = 1'b0;
                eval = 1'b1;
            end
        end
        if (blocked)
        begin
            st_nxt.raw = 1'b0; // [RQ3] [RQ4]
        end
        else if (eval)
        begin
            st_nxt.raw = st_r.raw ? !drop : pick; // [RQ16]
        end
        tick_hit = st_r.tick == 17'(TICK_CYCLES - 1);
        st_nxt.tick = tick_hit ? 17'h0 : st_r.tick + 17'h1;
        // Output delays count whole ticks from the change of the raw state.
        unique case (st_r.state)
            atc_pkg::ST_IDLE:
            begin
                if (st_r.raw && st_r.on_delay == 16'h0)
                begin
                    st_nxt.state = atc_pkg::ST_ACTIVE; // [RQ14]
                end
                else if (st_r.raw)
                begin
                    st_nxt.state = atc_pkg::ST_ARMING;
                    st_nxt.dcnt = 16'h0;
                    st_nxt.tick = 17'h0;
                end
            end
            atc_pkg::ST_ARMING:
            begin
                if (!st_r.raw)
                begin
                    st_nxt.state = atc_pkg::ST_IDLE;
                end
                else if (tick_hit)
                begin
                    st_nxt.dcnt = st_r.dcnt + 16'h1;
                    if (st_r.dcnt + 16'h1 >= st_r.on_delay)
                    begin
                        st_nxt.state = atc_pkg::ST_ACTIVE; // [RQ14]
                    end
                end
            end
            atc_pkg::ST_ACTIVE:
            begin
                if (!st_r.raw && st_r.off_delay == 16'h0)
                begin
                    st_nxt.state = atc_pkg::ST_IDLE; // [RQ14]
                end
                else if (!st_r.raw)
                begin
                    st_nxt.state = atc_pkg::ST_RELEASING;
                    st_nxt.dcnt = 16'h0;
                    st_nxt.tick = 17'h0;
                end
            end
            atc_pkg::ST_RELEASING:
            begin
                if (st_r.raw)
                begin
                    st_nxt.state = atc_pkg::ST_ACTIVE;
                end
                else if (tick_hit)
                begin
                    st_nxt.dcnt = st_r.dcnt + 16'h1;
                    if (st_r.dcnt + 16'h1 >= st_r.off_delay)
                    begin
                        st_nxt.state = atc_pkg::ST_IDLE; // [RQ14]
                    end
                end
            end
        endcase
        if (blocked)
        begin
            st_nxt.state = atc_pkg::ST_IDLE; // [RQ3] [RQ4]
        end
        st_nxt.flag = (st_nxt.state == atc_pkg::ST_ACTIVE)
            || (st_nxt.state == atc_pkg::ST_RELEASING);
        // Read data is captured in the setup phase.
        if (psel && !penable)
        begin
            st_nxt.prdata = 32'h0;
            unique case (paddr)
                atc_pkg::ADDR_CTRL: st_nxt.prdata = 32'(st_r.ctrl);
                atc_pkg::ADDR_THRESH: st_nxt.prdata = st_r.thresh;
                atc_pkg::ADDR_BAND: st_nxt.prdata = 32'(st_r.band);
                atc_pkg::ADDR_INTERVAL: st_nxt.prdata = 32'(st_r.interval);
                atc_pkg::ADDR_ON_DELAY: st_nxt.prdata = 32'(st_r.on_delay);
                atc_pkg::ADDR_OFF_DELAY: st_nxt.prdata = 32'(st_r.off_delay);
                atc_pkg::ADDR_STATUS: st_nxt.prdata = 32'({st_r.inhibit,
                    st_r.mismatch, st_r.raw, st_r.flag});
                atc_pkg::ADDR_OPSIG: st_nxt.prdata = st_r.op[31:0];
                default: st_nxt.prdata = 32'h0;
            endcase
        end
        wr_en = psel && penable && pwrite && addr_ok(paddr);
        if (wr_en)
        begin
            unique case (paddr)
                atc_pkg::ADDR_CTRL: st_nxt.ctrl = pwdata[atc_pkg::CTRL_W-1:0];
                atc_pkg::ADDR_THRESH: st_nxt.thresh = pwdata;
                atc_pkg::ADDR_BAND: st_nxt.band = pwdata[7:0];
                atc_pkg::ADDR_INTERVAL: st_nxt.interval = pwdata[7:0];
                atc_pkg::ADDR_ON_DELAY: st_nxt.on_delay = pwdata[15:0];
                atc_pkg::ADDR_OFF_DELAY: st_nxt.off_delay = pwdata[15:0];
                default: st_nxt.ctrl = st_r.ctrl;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_r <= '0;
            st_r.ctrl <= atc_pkg::CTRL_RST;
            st_r.thresh <= atc_pkg::THRESH_RST;
            st_r.band <= atc_pkg::BAND_RST;
            st_r.interval <= atc_pkg::INTERVAL_RST;
            st_r.on_delay <= atc_pkg::DELAY_RST;
            st_r.off_delay <= atc_pkg::DELAY_RST;
            st_r.state <= atc_pkg::ST_IDLE;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign prdata = st_r.prdata;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !addr_ok(paddr);
    assign element_operate = st_r.flag;
    assign element_pickup = st_r.raw;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    off_input_zero_a: assert property ( // [RQ1]
        sample_valid && !st_r.ctrl[atc_pkg::CTRL_NEG_EN]
        && !st_r.ctrl[atc_pkg::CTRL_MAG] && st_r.ctrl[atc_pkg::CTRL_POS_EN]
        |=> st_r.op == $past(35'(pos_value)))
        else $error("Disabled negative input did not read as zero.");
    diff_sign_a: assert property ( // [RQ2]
        sample_valid && st_r.ctrl[1:0] == 2'h3 && !st_r.ctrl[atc_pkg::CTRL_MAG]
        |=> st_r.op == $past(35'(pos_value) - 35'(neg_value)))
        else $error("Operating signal is not positive minus negative.");
    both_off_a: assert property ( // [RQ3]
        st_r.ctrl[1:0] == 2'h0 |=> !element_operate && !element_pickup)
        else $error("Output asserted with both inputs off.");
    type_clash_a: assert property ( // [RQ4]
        st_r.ctrl[1:0] == 2'h3 && pos_type != neg_type
        |=> !element_operate && !element_pickup)
        else $error("Output asserted with mismatched input types.");
    magnitude_a: assert property ( // [RQ5]
        sample_valid && st_r.ctrl[atc_pkg::CTRL_MAG] |=> !st_r.op[34])
        else $error("Magnitude mode produced a negative signal.");
    rate_window_a: assert property ( // [RQ7]
        st_r.ctrl[atc_pkg::CTRL_RATE] |-> st_r.scnt < ivl_eff)
        else $error("Rate sample count ran past the interval.");
    angle_base_a: assert property ( // [RQ12]
        st_r.ctrl[1:0] == 2'h1 && pos_type == atc_pkg::QTY_ANGLE
        |-> thr_n == 64'($signed(st_r.thresh)) * 64'sd360)
        else $error("Angle threshold not scaled by a full turn.");
    pickup_over_a: assert property ( // [RQ8]
        eval && !blocked && !st_r.raw && pick |=> element_pickup)
        else $error("Pickup missed with signal past threshold.");
    hold_band_a: assert property ( // [RQ16]
        eval && !blocked && st_r.raw && !drop |=> element_pickup)
        else $error("Dropped out inside the hysteresis band.");
    on_delay_a: assert property ( // [RQ14]
        $rose(element_operate) |-> $past(st_r.state) == atc_pkg::ST_IDLE
        ? $past(st_r.on_delay) == 16'h0
        : $past(st_r.dcnt) + 16'h1 >= $past(st_r.on_delay))
        else $error("Output asserted before the on delay elapsed.");

    rise_c: cover property ($rose(element_operate));
    rate_pick_c: cover property (st_r.ctrl[atc_pkg::CTRL_RATE]
        && $rose(element_pickup));
    release_c: cover property (st_r.state == atc_pkg::ST_RELEASING
        ##1 !element_operate);
    bus_error_c: cover property (pslverr);

endmodule // atc_comparator

// ==== sim/atc_meas_model.sv ====
// Purpose: Measurement engine model that feeds samples to the comparator.
// Assumes: Each sample is launched just after a rising edge of pclk.
// Notes: Values are inverted between samples so stale data is never reused.
module atc_meas_model (
    input wire logic pclk,
    output logic sample_valid,
    output logic signed [31:0] pos_value,
    output logic [3:0] pos_type,
    output logic signed [31:0] neg_value,
    output logic [3:0] neg_type
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        sample_valid = 1'b0;
        pos_value = 32'h0;
        neg_value = 32'h0;
        pos_type = 4'h1;
        neg_type = 4'h1;
    end

    // Presents one sample for one cycle, then scrambles the value lines.
    task automatic send(input logic [31:0] pv, input logic [31:0] nv,
                        input logic [3:0] pt, input logic [3:0] nt);
        @(posedge pclk);
        sample_valid <= 1'b1;
        pos_value <= pv;
        neg_value <= nv;
        pos_type <= pt;
        neg_type <= nt;
        @(posedge pclk);
        sample_valid <= 1'b0;
        pos_value <= ~pv;
        neg_value <= ~nv;
    endtask
endmodule // atc_meas_model

// ==== sim/analog_threshold_comparator_tb.sv ====
// Purpose: Self-checking bench for the analog threshold comparator.
// Assumes: Zero-wait APB slave; TICK_CYCLES set to 4 for short delays.
// Notes: Sample values are Q16.16, so 32'h0001_0000 stands for one.
module analog_threshold_comparator_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] ONE = 32'h0001_0000;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic sample_valid, element_operate, element_pickup;
    logic signed [31:0] pos_value, neg_value;
    logic [3:0] pos_type, neg_type, ty, tn;
    int bad_count, n_checks, cyc, n;
    logic [7:0] ra [6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14};
    logic [31:0] rv [6] = '{32'h1, ONE, 32'h2, 32'h1, 32'h0, 32'h0};
    logic [3:0] bt [3] = '{atc_pkg::QTY_ANGLE, atc_pkg::QTY_ENERGY_P,
                           atc_pkg::QTY_ENERGY_Q};
    logic [31:0] lo [3] = '{32'h012C_0000, 32'h2328_0000, 32'h2328_0000};
    logic [31:0] hi [3] = '{32'h0190_0000, 32'h2AF8_0000, 32'h2AF8_0000};

    atc_comparator #(.TICK_CYCLES(4)) u_dut (.pclk, .presetn, .psel,
        .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .sample_valid, .pos_value, .pos_type, .neg_value, .neg_type,
        .element_operate, .element_pickup);
    atc_meas_model u_meas (.pclk, .sample_valid, .pos_value, .pos_type,
        .neg_value, .neg_type);

    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task automatic give_verdict;
        $display("checks %0d, mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            bad_count++;
            give_verdict();
        end
    end

    task automatic chk(input string nm, input logic [31:0] exp,
                       input logic [31:0] got);
        n_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("unexpected %s: expected %h, seen %h", nm, exp, got);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] rd,
                       output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
        begin
            @(posedge pclk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic e;
        apb(1'b1, a, d, rd, e);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp,
                       input logic eexp);
        logic [31:0] rd;
        logic e;
        apb(1'b0, a, 32'h0, rd, e);
        chk($sformatf("reg %h", a), exp, rd);
        chk($sformatf("error %h", a), {31'h0, eexp}, {31'h0, e});
    endtask

    // Sends one sample and compares {pickup, operate} two edges later.
    task automatic smp(input logic [31:0] pv, input logic [31:0] nv,
                       input logic [1:0] ef);
        u_meas.send(pv, nv, ty, tn);
        @(posedge pclk);
        #1;
        chk("flags", {30'h0, ef}, {30'h0, element_pickup, element_operate});
    endtask

    task automatic wt(input logic v);
        n = 0;
        while (element_operate !== v && n < 40)
        begin
            @(posedge pclk);
            #1;
            n++;
        end
    endtask

    task automatic ramp(input logic [31:0] step, input logic ef);
        for (int k = 0; k < 8; k++)
            u_meas.send(32'h0005_0000 + k * step, 32'h0, ty, tn);
        repeat (2) @(posedge pclk);
        #1;
        chk("rate pickup", {31'h0, ef}, {31'h0, element_pickup});
    endtask

    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h0;
        pwdata = 32'h0;
        ty = atc_pkg::QTY_FREQ;
        tn = atc_pkg::QTY_FREQ;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        foreach (ra[i]) rdc(ra[i], rv[i], 1'b0);
        rdc(8'h20, 32'h0, 1'b1);
        rdc(8'h02, 32'h0, 1'b1);
        $display("test registers done");
        wr(8'h08, 32'h32);
        smp(32'h0000_CCCC, 32'h0, 2'b00);
        smp(ONE, 32'h0, 2'b00);
        smp(32'h0002_0000, 32'h0, 2'b11);
        rdc(8'h18, 32'h3, 1'b0);
        smp(32'h0000_CCCC, 32'h0, 2'b11);
        smp(32'h0000_6666, 32'h0, 2'b00);
        $display("test level over done");
        wr(8'h04, 32'hFFFF_0000);
        wr(8'h00, 32'h11);
        smp(32'hFFFF_8000, 32'h0, 2'b00);
        smp(32'hFFFE_0000, 32'h0, 2'b11);
        smp(32'hFFFF_3334, 32'h0, 2'b11);
        smp(32'hFFFF_999A, 32'h0, 2'b00);
        $display("test negative under done");
        wr(8'h04, ONE);
        wr(8'h00, 32'h2);
        smp(32'h0005_0000, 32'hFFFE_0000, 2'b11);
        smp(32'h0005_0000, 32'h0002_0000, 2'b00);
        wr(8'h00, 32'h3);
        smp(32'h0001_8000, ONE, 2'b00);
        smp(32'h0003_0000, ONE, 2'b11);
        rdc(8'h1C, 32'h0002_0000, 1'b0);
        wr(8'h00, 32'h5);
        smp(32'hFFFE_0000, 32'h0, 2'b11);
        wr(8'h00, 32'h1);
        smp(32'hFFFE_0000, 32'hFFFC_0000, 2'b00);
        $display("test input forming done");
        wr(8'h00, 32'h10);
        smp(32'h0005_0000, 32'h0, 2'b00);
        rdc(8'h18, 32'h8, 1'b0);
        wr(8'h00, 32'h3);
        tn = atc_pkg::QTY_ANGLE;
        smp(32'h0005_0000, 32'h0, 2'b00);
        rdc(8'h18, 32'h4, 1'b0);
        $display("test inhibit done");
        wr(8'h00, 32'h1);
        foreach (bt[i])
        begin
            ty = bt[i];
            tn = bt[i];
            smp(lo[i], 32'h0, 2'b00);
            smp(hi[i], 32'h0, 2'b11);
            smp(32'h0, 32'h0, 2'b00);
        end
        ty = atc_pkg::QTY_FREQ_RATE;
        tn = ty;
        smp(32'h0000_C000, 32'h0, 2'b00);
        smp(32'h0001_4000, 32'h0, 2'b11);
        smp(32'h0, 32'h0, 2'b00);
        $display("test bases done");
        wr(8'h10, 32'h2);
        wr(8'h14, 32'h1);
        smp(32'h0002_0000, 32'h0, 2'b10);
        wt(1'b1);
        chk("on wait", 32'h1, {31'h0, n >= 6 && n <= 10});
        smp(32'h0, 32'h0, 2'b01);
        wt(1'b0);
        chk("off wait", 32'h1, {31'h0, n >= 1 && n <= 6});
        wr(8'h10, 32'h0);
        wr(8'h14, 32'h0);
        $display("test delays done");
        wr(8'h0C, 32'h2);
        wr(8'h00, 32'h9);
        ramp(32'h0, 1'b0);
        ramp(32'h0000_8000, 1'b0);
        ramp(32'h0001_8000, 1'b1);
        wr(8'h00, 32'h21);
        wr(8'h0C, 32'hC8);
        smp(32'h0, 32'h0, 2'b00);
        smp(32'h0002_0000, 32'h0, 2'b11);
        smp(32'h0, 32'h0, 2'b00);
        wr(8'h00, 32'h29);
        wr(8'h0C, 32'h1);
        ramp(32'h0001_8000, 1'b0);
        $display("test rate done");
        give_verdict();
    end
endmodule // analog_threshold_comparator_tb
